// ===== csp_consts.svh
// constants for the codec serial port enable and timing block
// Overview of operation
// - port enable is asynchronous, no clock edge
// - disabled: outputs released, inputs ignored
// - disabled: serial shift clock stopped
// - re-enable keeps control and data registers
// - re-enable restarts counters and state machines
// - four sample rates per channel, field B
// - sample tick refreshes adc and dac registers
// - five read/write control registers, A to E
// - control registers eight bits, bit 7 MSB
// - internal master clock divides external clock
// - output bits launched on serial clock rise
// - input bits captured on serial clock fall
// - one-bit frame sync before word MSB
// - serial clock = mclk / (mdiv * sdiv)
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

`define CSP_NUM_CH      2
`define CSP_NUM_REGS    5
`define CSP_MEM_WORDS   10
`define CSP_REG_A       3'h0
`define CSP_REG_B       3'h1
`define CSP_REG_C       3'h2
`define CSP_REG_D       3'h3
`define CSP_REG_E       3'h4
`define CSP_REG_RESET   8'h00
`define CSP_WORD_MSB    4'hF
// control register B field positions
`define CSP_REGB_RATE_LSB 0
`define CSP_REGB_MCD_LSB  2
`define CSP_REGB_SCD_LSB  5
// fastest sample period in internal master clock ticks
`define CSP_RATE_BASE   12'h100
// control word field positions
`define CSP_CW_CTRL     15
`define CSP_CW_READ     14
`define CSP_CW_IDX_LSB  11
`define CSP_CW_CH       10

`endif

// ===== csp_pkg.sv
// types shared by the codec serial port files
package csp_pkg;
  typedef logic [15:0] csp_word_t;
  typedef logic [7:0]  csp_byte_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_BITS} csp_tx_t;
  typedef enum logic [0:0] {RX_IDLE, RX_BITS} csp_rx_t;
endpackage

// ===== csp_clkdiv.sv
// master clock divider and serial shift clock generator
`timescale 1ns/10ps
`include "csp_consts.svh"
module csp_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] mclk_sel,
  input  wire logic [1:0] sclk_sel,
  output logic            master_tick,
  output logic            sclk,
  output logic            sclk_rise,
  output logic            sclk_fall
);
  import csp_pkg::*;

  logic [2:0] mcnt;
  logic [2:0] next_mcnt;
  logic [2:0] scnt;
  logic [2:0] next_scnt;
  logic       next_sclk;
  logic       toggle;
  logic [2:0] half_last;

  // divide clk by mclk_sel+1, then toggle sclk every 2^sclk_sel ticks
  always_comb begin
    half_last  = 3'((4'h1 << sclk_sel) - 4'h1);
    master_tick = run && (mcnt == mclk_sel);
    toggle     = master_tick && (scnt == half_last);
    sclk_rise  = toggle && !sclk;
    sclk_fall  = toggle && sclk;
    next_mcnt  = master_tick ? 3'h0 : 3'(mcnt + 3'h1);
    next_scnt  = scnt;
    next_sclk  = sclk;
    if (master_tick) begin
      next_scnt = toggle ? 3'h0 : 3'(scnt + 3'h1);
    end
    if (toggle) begin
      next_sclk = !sclk;
    end
    if (!run) begin
      next_mcnt = 3'h0;
      next_scnt = 3'h0;
      next_sclk = 1'b0;
    end
  end

  // divider registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mcnt <= 3'h0;
      scnt <= 3'h0;
      sclk <= 1'b0;
    end else begin
      mcnt <= next_mcnt;
      scnt <= next_scnt;
      sclk <= next_sclk;
    end
  end

  a_sclk_stopped: assert property (@(posedge clk)
    disable iff (rst) !run |-> !sclk_rise ##1 !sclk)
    else $error("serial clock runs while port disabled");

  // mdiv 2 and sdiv 4 give a rise every eight clocks
  a_sclk_ratio: assert property (@(posedge clk) disable iff (rst)
    sclk_rise && mclk_sel == 3'h1 && sclk_sel == 2'h1 && run
      ##1 (run && mclk_sel == 3'h1 && sclk_sel == 2'h1)[*7]
      |-> ##1 sclk_rise)
    else $error("serial clock period not mdiv times sdiv");
endmodule

// ===== csp_regfile.sv
// control register storage for both channels, registered read
`timescale 1ns/10ps
`include "csp_consts.svh"
module csp_regfile (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  input  wire logic [3:0]       addr,
  input  wire csp_pkg::csp_byte_t wr_data,
  output csp_pkg::csp_byte_t    rd_data,
  output csp_pkg::csp_byte_t    ctrl_b0,
  output csp_pkg::csp_byte_t    ctrl_b1
);
  import csp_pkg::*;

  logic [`CSP_MEM_WORDS-1:0][7:0] mem;
  logic [`CSP_MEM_WORDS-1:0][7:0] next_mem;
  csp_byte_t                      next_rd_data;

  // eight-bit registers A..E per channel, address = chan*5 + index
  always_comb begin
    next_mem     = mem;
    next_rd_data = rd_data;
    if (wr_en) begin
      next_mem[addr] = wr_data;
    end
    if (rd_en) begin
      next_rd_data = mem[addr];
    end
  end

  // only the chip reset clears the registers, never the port enable
  always_ff @(posedge clk) begin
    if (rst) begin
      mem     <= {`CSP_MEM_WORDS{`CSP_REG_RESET}};
      rd_data <= `CSP_REG_RESET;
    end else begin
      mem     <= next_mem;
      rd_data <= next_rd_data;
    end
  end

  assign ctrl_b0 = mem[4'(`CSP_REG_B)];
  assign ctrl_b1 = mem[4'(`CSP_NUM_REGS) + 4'(`CSP_REG_B)];

  a_mem_held: assert property (@(posedge clk) disable iff (rst)
    !wr_en |=> $stable(mem))
    else $error("control register changed without a write");
endmodule

// ===== csp_port.sv
// codec serial port with asynchronous enable, gating and sample timing
`timescale 1ns/10ps
`include "csp_consts.svh"
module csp_port (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              port_enable_pin,
  input  wire logic              serial_data_input,
  input  wire logic              input_frame_sync,
  input  wire csp_pkg::csp_word_t adc_sample_ch0,
  input  wire csp_pkg::csp_word_t adc_sample_ch1,
  output logic                   sclk,
  output logic                   serial_data_output,
  output logic                   serial_data_output_oe,
  output logic                   output_frame_sync,
  output logic                   output_frame_sync_oe,
  output csp_pkg::csp_word_t     dac_sample_ch0,
  output csp_pkg::csp_word_t     dac_sample_ch1
);
  import csp_pkg::*;

  // enable synchroniser
  logic en_meta;
  logic en_sync;
  logic next_en_meta;
  logic next_en_sync;
  logic run;

  // clock divider outputs
  logic master_tick;
  logic sclk_rise;
  logic sclk_fall;

  // register file port
  logic      reg_wr;
  logic      reg_rd;
  logic [3:0] reg_addr;
  csp_byte_t reg_rd_data;
  csp_byte_t ctrl_b0;
  csp_byte_t ctrl_b1;

  // per channel sample path
  logic      tick [`CSP_NUM_CH];
  csp_word_t adc_in [`CSP_NUM_CH];
  csp_word_t adc_out [`CSP_NUM_CH];
  csp_word_t dac_in [`CSP_NUM_CH];
  csp_word_t dac_out [`CSP_NUM_CH];

  // transmit side
  csp_tx_t   tx_state;
  csp_tx_t   next_tx_state;
  logic [3:0] tx_cnt;
  logic [3:0] next_tx_cnt;
  logic      tx_chan;
  logic      next_tx_chan;
  csp_word_t tx_word;
  csp_word_t next_tx_word;
  logic      tx_pend;
  logic      next_tx_pend;
  logic      next_dout;
  logic      next_dout_oe;
  logic      next_fs;
  logic      next_fs_oe;

  // receive side and read replies
  csp_rx_t   rx_state;
  csp_rx_t   next_rx_state;
  logic [3:0] rx_cnt;
  logic [3:0] next_rx_cnt;
  csp_word_t rx_word;
  csp_word_t next_rx_word;
  logic      rx_chan;
  logic      next_rx_chan;
  logic      rd_pend;
  logic      next_rd_pend;
  logic [3:0] rd_tag;
  logic [3:0] next_rd_tag;
  logic      reply_valid;
  logic      next_reply_valid;
  csp_word_t reply_word;
  csp_word_t next_reply_word;
  logic      rx_done;
  csp_word_t rx_full;
  logic [2:0] rx_idx;
  logic [3:0] rx_base;
  logic      dac_wr [`CSP_NUM_CH];

  // the pin changes with no regard to any clock, so it is resynchronised
  always_comb begin
    next_en_meta = port_enable_pin;
    next_en_sync = en_meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      en_meta <= next_en_meta;
      en_sync <= next_en_sync;
    end
  end

  assign run = en_sync;

  csp_clkdiv u_clkdiv (
    .clk        (clk),
    .rst        (rst),
    .run        (run),
    .mclk_sel   (ctrl_b0[`CSP_REGB_MCD_LSB +: 3]),
    .sclk_sel   (ctrl_b0[`CSP_REGB_SCD_LSB +: 2]),
    .master_tick (master_tick),
    .sclk       (sclk),
    .sclk_rise  (sclk_rise),
    .sclk_fall  (sclk_fall)
  );

  csp_regfile u_regfile (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (reg_wr),
    .rd_en   (reg_rd),
    .addr    (reg_addr),
    .wr_data (rx_full[7:0]),
    .rd_data (reg_rd_data),
    .ctrl_b0 (ctrl_b0),
    .ctrl_b1 (ctrl_b1)
  );

  assign adc_in[0]      = adc_sample_ch0;
  assign adc_in[1]      = adc_sample_ch1;
  assign dac_sample_ch0 = dac_out[0];
  assign dac_sample_ch1 = dac_out[1];

  // sample rate timer and converter registers, one set per channel
  for (genvar i = 0; i < `CSP_NUM_CH; i++) begin : g_ch
    logic [11:0] cnt;
    logic [11:0] next_cnt;
    logic [11:0] period;
    logic [1:0]  rate;
    csp_word_t   next_adc;
    csp_word_t   next_dac_in;
    csp_word_t   next_dac_out;

    always_comb begin
      rate   = (i == 0) ? ctrl_b0[`CSP_REGB_RATE_LSB +: 2]
                        : ctrl_b1[`CSP_REGB_RATE_LSB +: 2];
      period = 12'(`CSP_RATE_BASE << (2'h3 - rate));
      tick[i] = master_tick && (cnt == 12'(period - 12'h1));
      next_cnt = cnt;
      if (master_tick) begin
        next_cnt = tick[i] ? 12'h0 : 12'(cnt + 12'h1);
      end
      if (!run) begin
        next_cnt = 12'h0;
      end
      next_adc     = tick[i] ? adc_in[i] : adc_out[i];
      next_dac_out = tick[i] ? dac_in[i] : dac_out[i];
      next_dac_in  = dac_wr[i] ? rx_full : dac_in[i];
    end

    // sample data survive a disable, only chip reset clears them
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt        <= 12'h0;
        adc_out[i] <= 16'h0000;
        dac_in[i]  <= 16'h0000;
        dac_out[i] <= 16'h0000;
      end else begin
        cnt        <= next_cnt;
        adc_out[i] <= next_adc;
        dac_in[i]  <= next_dac_in;
        dac_out[i] <= next_dac_out;
      end
    end

    a_tick_dac: assert property (@(posedge clk) disable iff (rst)
      tick[i] |=> dac_out[i] == $past(dac_in[i])
        && adc_out[i] == $past(adc_in[i]))
      else $error("sample tick did not refresh converter registers");
  end

  // transmit: frame sync one bit ahead of the MSB, bits on each rise
  always_comb begin
    next_tx_state    = tx_state;
    next_tx_cnt      = tx_cnt;
    next_tx_chan     = tx_chan;
    next_tx_word     = tx_word;
    next_tx_pend     = tx_pend;
    next_dout        = serial_data_output;
    next_dout_oe     = serial_data_output_oe;
    next_fs          = output_frame_sync;
    next_fs_oe       = run;
    next_reply_valid = reply_valid;
    next_reply_word  = reply_word;
    if (rd_pend) begin
      next_reply_valid = 1'b1;
      next_reply_word  = {2'b11, rd_tag[2:0], rd_tag[3], 2'b00, reg_rd_data};
    end
    if (sclk_rise) begin
      unique case (tx_state)
        TX_IDLE: begin
          if (tx_pend) begin
            next_tx_pend  = 1'b0;
            next_tx_chan  = 1'b0;
            next_tx_state = TX_SYNC;
            next_fs       = 1'b1;
          end
        end
        TX_SYNC: begin
          next_fs       = 1'b0;
          next_tx_state = TX_BITS;
          next_tx_cnt   = `CSP_WORD_MSB;
          next_tx_word  = reply_valid ? reply_word : adc_out[tx_chan];
          next_reply_valid = rd_pend;
          next_dout     = next_tx_word[`CSP_WORD_MSB];
          next_dout_oe  = 1'b1;
        end
        TX_BITS: begin
          if (tx_cnt == 4'h0) begin
            next_dout_oe = 1'b0;
            next_dout    = 1'b0;
            if (!tx_chan) begin
              next_tx_chan  = 1'b1;
              next_tx_state = TX_SYNC;
              next_fs       = 1'b1;
            end else begin
              next_tx_state = TX_IDLE;
            end
          end else begin
            next_tx_cnt = 4'(tx_cnt - 4'h1);
            next_dout   = tx_word[next_tx_cnt];
          end
        end
      endcase
    end
    if (tick[0]) begin
      next_tx_pend = 1'b1;                               // set beats clear
    end
    if (!run) begin
      next_tx_state = TX_IDLE;
      next_tx_cnt   = 4'h0;
      next_tx_chan  = 1'b0;
      next_tx_pend  = 1'b0;
      next_dout     = 1'b0;
      next_dout_oe  = 1'b0;
      next_fs       = 1'b0;
      next_reply_valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state              <= TX_IDLE;
      tx_cnt                <= 4'h0;
      tx_chan               <= 1'b0;
      tx_word               <= 16'h0000;
      tx_pend               <= 1'b0;
      serial_data_output    <= 1'b0;
      serial_data_output_oe <= 1'b0;
      output_frame_sync     <= 1'b0;
      output_frame_sync_oe  <= 1'b0;
      reply_valid           <= 1'b0;
      reply_word            <= 16'h0000;
    end else begin
      tx_state              <= next_tx_state;
      tx_cnt                <= next_tx_cnt;
      tx_chan               <= next_tx_chan;
      tx_word               <= next_tx_word;
      tx_pend               <= next_tx_pend;
      serial_data_output    <= next_dout;
      serial_data_output_oe <= next_dout_oe;
      output_frame_sync     <= next_fs;
      output_frame_sync_oe  <= next_fs_oe;
      reply_valid           <= next_reply_valid;
      reply_word            <= next_reply_word;
    end
  end

  // receive: frame sync and bits sampled on each fall, decode at word end
  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_word  = rx_word;
    rx_done       = 1'b0;
    rx_full       = {rx_word[14:0], serial_data_input};
    if (sclk_fall) begin
      unique case (rx_state)
        RX_IDLE: begin
          if (input_frame_sync) begin
            next_rx_state = RX_BITS;
            next_rx_cnt   = `CSP_WORD_MSB;
          end
        end
        RX_BITS: begin
          next_rx_word = rx_full;
          if (rx_cnt == 4'h0) begin
            rx_done       = 1'b1;
            next_rx_state = RX_IDLE;
          end else begin
            next_rx_cnt = 4'(rx_cnt - 4'h1);
          end
        end
      endcase
    end
    rx_idx   = rx_full[`CSP_CW_IDX_LSB +: 3];
    rx_base  = rx_full[`CSP_CW_CH] ? 4'(`CSP_NUM_REGS) : 4'h0;
    reg_addr = 4'(rx_base + {1'b0, rx_idx});
    reg_wr   = run && rx_done && rx_full[`CSP_CW_CTRL]
               && !rx_full[`CSP_CW_READ] && (rx_idx <= `CSP_REG_E);
    reg_rd   = run && rx_done && rx_full[`CSP_CW_CTRL]
               && rx_full[`CSP_CW_READ] && (rx_idx <= `CSP_REG_E);
    next_rd_pend = reg_rd;
    next_rd_tag  = reg_rd ? {rx_full[`CSP_CW_CH], rx_idx} : rd_tag;
    next_rx_chan = rx_chan;
    dac_wr[0] = run && rx_done && !rx_full[`CSP_CW_CTRL] && !rx_chan;
    dac_wr[1] = run && rx_done && !rx_full[`CSP_CW_CTRL] && rx_chan;
    if (run && rx_done && !rx_full[`CSP_CW_CTRL]) begin
      next_rx_chan = !rx_chan;
    end
    if (!run) begin
      next_rx_state = RX_IDLE;
      next_rx_cnt   = 4'h0;
      next_rx_chan  = 1'b0;
      next_rd_pend  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 4'h0;
      rx_word  <= 16'h0000;
      rx_chan  <= 1'b0;
      rd_pend  <= 1'b0;
      rd_tag   <= 4'h0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_word  <= next_rx_word;
      rx_chan  <= next_rx_chan;
      rd_pend  <= next_rd_pend;
      rd_tag   <= next_rd_tag;
    end
  end

  a_enable_synced: assert property (@(posedge clk)
    disable iff (rst) ##2 1 |-> en_sync == $past(port_enable_pin, 2))
    else $error("enable not passed through two flops");

  a_pins_released: assert property (@(posedge clk)
    disable iff (rst)
    !run |=> !serial_data_output_oe && !output_frame_sync_oe)
    else $error("outputs driven while port disabled");

  a_state_restart: assert property (@(posedge clk)
    disable iff (rst)
    !run |=> tx_state == TX_IDLE && rx_state == RX_IDLE && tx_cnt == 4'h0
      && rx_cnt == 4'h0 && !tx_pend)
    else $error("timing state not at reset value while disabled");

  // control and sample words must not move while the port is off
  a_regs_kept: assert property (@(posedge clk) disable iff (rst)
    !run |=> $stable(ctrl_b0) && $stable(ctrl_b1)
      && $stable(dac_in[0]) && $stable(dac_in[1]))
    else $error("register written while port disabled");

  a_fs_one_bit: assert property (@(posedge clk) disable iff (rst)
    tx_state == TX_SYNC && sclk_rise && run
      |=> !output_frame_sync && serial_data_output_oe)
    else $error("frame sync not one bit before MSB");

  a_launch_rise: assert property (@(posedge clk) disable iff (rst)
    $changed(serial_data_output) |-> $past(sclk_rise) || !$past(run))
    else $error("output bit changed away from a rising edge");
endmodule

// ===== csp_host.sv
// host serial port model: sends words on the input pins, collects outputs
`timescale 1ns/10ps
module csp_host
  import csp_pkg::*;
(
  input  wire logic clk,
  input  wire logic sclk,
  input  wire logic dout,
  input  wire logic dout_oe,
  input  wire logic ofs,
  input  wire logic ofs_oe,
  output logic      din,
  output logic      ifs
);
  csp_word_t tx_q[$];
  csp_word_t rx_q[$];
  csp_word_t tx_sh;
  csp_word_t rx_sh;
  int        tx_cnt = 0;
  int        rx_cnt = 0;
  logic      s_prev = 1'b0;
  logic      tick = 1'b0;
  logic      own_clk = 1'b0;
  logic      dout_last = 1'b0;
  logic      ofs_last = 1'b0;
  logic      dout_line;
  logic      ofs_line;
  logic      launch;
  logic      sample;

  // released outputs read back as the inverse of their last value
  assign dout_line = dout_oe ? dout : ~dout_last;
  assign ofs_line = ofs_oe ? ofs : ~ofs_last;
  // launch just after the shift clock rises, or every other clk when own_clk is set; sample just after it falls
  assign launch = own_clk ? tick : (sclk & ~s_prev);
  assign sample = ~sclk & s_prev;

  // idle levels at time zero
  initial begin
    din = 1'b0;
    ifs = 1'b0;
  end

  // transmit port drives the input pins, receive port takes outputs
  always @(posedge clk) begin
    s_prev <= sclk;
    tick   <= ~tick;
    if (dout_oe)
      dout_last <= dout;
    if (ofs_oe)
      ofs_last <= ofs;
    if (launch) begin
      if (tx_cnt > 0) begin
        ifs    <= 1'b0;
        din    <= tx_sh[15];
        tx_sh  <= {tx_sh[14:0], 1'b0};
        tx_cnt <= tx_cnt - 1;
      end else if (tx_q.size() > 0) begin
        ifs    <= 1'b1;
        din    <= ~din;
        tx_sh  <= tx_q.pop_front();
        tx_cnt <= 16;
      end else begin
        ifs <= 1'b0;
        din <= ~din; // line not held between words
      end
    end
    if (sample) begin
      if (rx_cnt > 0) begin
        rx_sh  <= {rx_sh[14:0], dout_line};
        rx_cnt <= rx_cnt - 1;
        if (rx_cnt == 1)
          rx_q.push_back({rx_sh[14:0], dout_line});
      end else if (ofs_line === 1'b1) begin
        rx_cnt <= 16;
      end
    end
  end
endmodule

// ===== tb.sv
// self-checking bench for the codec serial port
`timescale 1ns/10ps
module tb;
  import csp_pkg::*;
  logic      clk;
  logic      rst;
  logic      en;
  logic      sclk;
  logic      dout;
  logic      dout_oe;
  logic      ofs;
  logic      ofs_oe;
  logic      din;
  logic      ifs;
  csp_word_t adc0;
  csp_word_t adc1;
  csp_word_t dac0;
  csp_word_t dac1;
  int        fails = 0;
  int        checks_done = 0;

  csp_port dut (.clk(clk), .rst(rst), .port_enable_pin(en),
    .serial_data_input(din), .input_frame_sync(ifs),
    .adc_sample_ch0(adc0), .adc_sample_ch1(adc1), .sclk(sclk),
    .serial_data_output(dout), .serial_data_output_oe(dout_oe),
    .output_frame_sync(ofs), .output_frame_sync_oe(ofs_oe),
    .dac_sample_ch0(dac0), .dac_sample_ch1(dac1));

  csp_host u_host (.clk(clk), .sclk(sclk), .dout(dout), .dout_oe(dout_oe),
    .ofs(ofs), .ofs_oe(ofs_oe), .din(din), .ifs(ifs));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare tasks, one per kind of result
  task automatic chk_bit(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(string what, csp_word_t exp, csp_word_t got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_int(string what, int exp, int got);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // control word: flag, read, index, channel, data
  function automatic csp_word_t cw(logic rd, int idx, logic ch, csp_byte_t d);
    return {1'b1, rd, idx[2:0], ch, 2'b00, d};
  endfunction

  // next word collected by the host, bounded wait
  task automatic get_word(output csp_word_t w);
    int n;
    n = 0;
    w = 16'h0000;
    while (u_host.rx_q.size() == 0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (u_host.rx_q.size() == 0) begin
      fails++;
      $display("CHECK FAILED word arrival expected word seen none");
    end else begin
      w = u_host.rx_q.pop_front();
    end
  endtask

  // queue a word behind any already queued, wait until all have gone
  task automatic send(csp_word_t w);
    int n;
    n = 0;
    u_host.tx_q.push_back(w);
    @(posedge clk);
    while ((u_host.tx_q.size() != 0 || u_host.tx_cnt != 0) && n < 5000) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
  endtask

  // wait for a gap of 100 cycles with no frame on the output
  task automatic quiet();
    int q;
    int n;
    q = 0;
    n = 0;
    while (q < 100 && n < 5000) begin
      @(posedge clk);
      n++;
      q = (ofs === 1'b0 && u_host.rx_cnt == 0) ? q + 1 : 0;
    end
  endtask

  // read a register and compare the reply word
  task automatic rd_chk(int idx, logic ch, csp_byte_t exp);
    csp_word_t w;
    int        k;
    u_host.rx_q.delete();
    send(cw(1'b1, idx, ch, 8'h00));
    w = 16'h0000;
    for (k = 0; k < 6 && w[15] !== 1'b1; k++)
      get_word(w);
    chk_word("read reply", cw(1'b1, idx, ch, exp), w);
  endtask

  // cycles spanned by rises of shift clock (sel 1) or frame sync (sel 0)
  task automatic rise_gap(int sel, output int p);
    int   n;
    int   hits;
    int   t0;
    logic s;
    logic prev;
    n = 0;
    hits = 0;
    t0 = 0;
    prev = 1'b1;
    while (hits < 3 - sel && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
      s = sel ? sclk : ofs;
      if (s === 1'b1 && prev !== 1'b1) begin
        hits++;
        if (hits == 1)
          t0 = n;
      end
      prev = s;
    end
    p = n - t0;
  endtask

  // reset values, write and read back, refused index
  task automatic t_regs();
    int i;
    send(cw(1'b0, 1, 1'b0, 8'h03));
    for (i = 0; i < 10; i++)
      rd_chk(i % 5, i >= 5, (i == 1) ? 8'h03 : 8'h00);
    for (i = 0; i < 10; i++)
      if (i != 1)
        send(cw(1'b0, i % 5, i >= 5, {i[3:0], ~i[3:0]}));
    send(cw(1'b0, 5, 1'b0, 8'hFF));
    for (i = 0; i < 10; i++)
      rd_chk(i % 5, i >= 5, (i == 1) ? 8'h03 : {i[3:0], ~i[3:0]});
  endtask

  // four sample rates, then both dividers
  task automatic t_rates();
    int s;
    int p;
    for (s = 0; s < 4; s++) begin
      send(cw(1'b0, 1, 1'b0, 8'(s)));
      rise_gap(0, p);
      rise_gap(0, p);
      chk_int("sample period", 256 << (3 - s), p);
    end
    send(cw(1'b0, 1, 1'b0, 8'h27));
    rise_gap(1, p);
    rise_gap(1, p);
    chk_int("shift clock period", 8, p);
    rise_gap(0, p);
    rise_gap(0, p);
    chk_int("divided sample period", 512, p);
    send(cw(1'b0, 1, 1'b0, 8'h03));
  endtask

  // disable with traffic on the inputs, then re-enable
  task automatic t_disable();
    int        n;
    int        bad;
    csp_word_t w0;
    csp_word_t w1;
    send(cw(1'b0, 0, 1'b0, 8'h5A));
    quiet();
    en <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_bit("data output enable", 1'b0, dout_oe);
    chk_bit("frame sync enable", 1'b0, ofs_oe);
    u_host.own_clk = 1'b1;
    u_host.tx_q.push_back(cw(1'b0, 0, 1'b0, 8'hC3));
    u_host.tx_q.push_back(16'h7777);
    bad = 0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      if (sclk !== 1'b0 || dout_oe !== 1'b0 || ofs_oe !== 1'b0)
        bad++;
    end
    chk_int("activity while disabled", 0, bad);
    u_host.own_clk = 1'b0;
    @(posedge clk);
    en <= 1'b1;
    adc0 <= 16'h2BCD;
    adc1 <= 16'h0ACE;
    repeat (8) @(posedge clk);
    #1;
    chk_bit("frame sync enable", 1'b1, ofs_oe);
    rd_chk(0, 1'b0, 8'h5A);
    u_host.tx_q.push_back(16'h1357);
    send(16'h2468);
    n = 0;
    while ((dac0 !== 16'h1357 || dac1 !== 16'h2468) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk_word("dac channel 0", 16'h1357, dac0);
    chk_word("dac channel 1", 16'h2468, dac1);
    quiet();
    u_host.rx_q.delete();
    get_word(w0);
    get_word(w1);
    chk_word("adc word channel 0", 16'h2BCD, w0);
    chk_word("adc word channel 1", 16'h0ACE, w1);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    en = 1'b1;
    adc0 = 16'h1234;
    adc1 = 16'h0567;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_regs();
    t_rates();
    t_disable();
    stop_test();
  end

  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    $display("CHECK FAILED watchdog expected end seen hang");
    stop_test();
  end
endmodule
